// *** src/rhg_top.sv ***
// random number health gate: start-up testing, word assembly, output gating
`timescale 1ns/100ps
module rhg_top #(
   parameter int WORD_W = rhg_pkg::RHG_WORD_W,
   parameter int WIN_BITS = rhg_pkg::RHG_WIN_BITS,
   parameter int RC_LIMIT = rhg_pkg::RHG_RC_LIMIT,
   parameter int STARTUP_WINS = rhg_pkg::RHG_STARTUP_WINS
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // generator control
   input wire logic START,
   input wire logic ALT_MODE,
   // entropy source
   input wire logic RAW_VALID,
   input wire logic RAW_BIT,
   // external fault reports
   input wire logic PP_FAULT,
   input wire logic SW_FAIL,
   // random word to the processor
   output logic [WORD_W-1:0] RND_WORD,
   output logic RND_VALID,
   input wire logic RD_ACK,
   // status
   output logic ACTIVE,
   output logic FAIL_TOTAL,
   output logic FAIL_ONLINE,
   output logic FAIL_HEALTH,
   output logic FAIL_MALF,
   output logic FAIL_SW
);
   import rhg_pkg::*;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (WORD_W != RHG_WORD_W) begin : g_bad_word
      $error("rhg_top: word width must be 16");
   end
   if (WIN_BITS < RHG_ON_HI + 1 || RC_LIMIT < 2 || STARTUP_WINS < 1) begin : g_bad_test
      $error("rhg_top: test geometry cannot be served");
   end

   localparam int BW = $clog2(WORD_W);
   localparam int SW = $clog2(STARTUP_WINS + 1);

   rhg_state_t state_q, state_d;
   logic [WORD_W-1:0] sr_q, word_q;
   logic [BW-1:0] bit_cnt_q;
   logic [SW-1:0] win_ok_q;
   logic full_q, pend_q, valid_q;
   logic f_total_q, f_online_q, f_health_q, f_malf_q, f_sw_q;
   logic ht_total, ht_online, ht_health, ht_done;

   // ----------------------------------------------------------------
   // raw bit tests
   // ----------------------------------------------------------------
   wire testing = (state_q == RHG_STARTUP) || (state_q == RHG_RUN);
   wire bit_in = testing && RAW_VALID;

   rhg_health #(
      .WIN_BITS(WIN_BITS),
      .RC_LIMIT(RC_LIMIT)
   ) u_health (
      .clk(CLK),
      .rst_n(RST_N),
      .clear(!testing),
      .bit_valid(bit_in),
      .bit_in(RAW_BIT),
      .total_fail(ht_total),
      .online_fail(ht_online),
      .health_fail(ht_health),
      .win_done(ht_done)
   );

   // ----------------------------------------------------------------
   // failure causes
   // ----------------------------------------------------------------
   wire ev_total = testing && ht_total;
   wire ev_online = testing && ht_online;
   wire ev_health = testing && ALT_MODE && ht_health;
   wire ev_malf = testing && ALT_MODE && PP_FAULT;
   wire ev_sw = testing && SW_FAIL;
   wire fail_now = ev_total || ev_online || ev_health || ev_malf || ev_sw;
   wire any_fail = f_total_q || f_online_q || f_health_q || f_malf_q || f_sw_q;
   wire win_pass = ht_done && !fail_now;
   wire startup_done = win_pass && (win_ok_q == SW'(STARTUP_WINS - 1));

   // ----------------------------------------------------------------
   // generator sequence
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         RHG_OFF: begin
            if (START) begin
               state_d = RHG_STARTUP;
            end
         end
         RHG_STARTUP: begin
            if (!START) begin
               state_d = RHG_OFF;
            end else if (fail_now) begin
               state_d = RHG_FAILED;
            end else if (startup_done) begin
               state_d = RHG_RUN;
            end
         end
         RHG_RUN: begin
            if (!START) begin
               state_d = RHG_OFF;
            end else if (fail_now) begin
               state_d = RHG_FAILED;
            end
         end
         RHG_FAILED: begin
            // only a restart leaves here
            if (!START) begin
               state_d = RHG_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= RHG_OFF;
         win_ok_q <= '0;
      end else begin
         state_q <= state_d;
         if (state_q != RHG_STARTUP) begin
            win_ok_q <= '0;
         end else if (win_pass) begin
            win_ok_q <= SW'(win_ok_q + 1'b1);
         end
      end
   end

   // ----------------------------------------------------------------
   // latched failure status
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         f_total_q <= 1'b0;
         f_online_q <= 1'b0;
         f_health_q <= 1'b0;
         f_malf_q <= 1'b0;
         f_sw_q <= 1'b0;
      end else if (state_q == RHG_OFF) begin
         f_total_q <= 1'b0;
         f_online_q <= 1'b0;
         f_health_q <= 1'b0;
         f_malf_q <= 1'b0;
         f_sw_q <= 1'b0;
      end else begin
         // sticky until restart, one flag per cause
         f_total_q <= f_total_q || ev_total;
         f_online_q <= f_online_q || ev_online;
         f_health_q <= f_health_q || ev_health;
         f_malf_q <= f_malf_q || ev_malf;
         f_sw_q <= f_sw_q || ev_sw;
      end
   end

   // ----------------------------------------------------------------
   // word assembly and delivery
   // ----------------------------------------------------------------
   // a finished word waits one cycle so a failure pulse raised by its
   // last bit can still drop it
   wire collect = (state_q == RHG_RUN) && RAW_VALID && !fail_now;
   wire last_bit = (bit_cnt_q == BW'(WORD_W - 1));
   wire deliver = pend_q && !fail_now && !any_fail && (!valid_q || RD_ACK);
   // a stop withdraws the word on the same edge that drops ACTIVE
   wire gate_ok = (state_q == RHG_RUN) && START && !fail_now && !any_fail;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sr_q <= '0;
         bit_cnt_q <= '0;
         full_q <= 1'b0;
      end else if (!gate_ok) begin
         // partial word may hold bits from after the failure
         bit_cnt_q <= '0;
         full_q <= 1'b0;
      end else if (collect && !full_q) begin
         sr_q <= {sr_q[WORD_W-2:0], RAW_BIT};
         bit_cnt_q <= last_bit ? '0 : BW'(bit_cnt_q + 1'b1);
         full_q <= last_bit;
      end else if (deliver) begin
         full_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pend_q <= 1'b0;
         valid_q <= 1'b0;
         word_q <= '0;
      end else begin
         pend_q <= gate_ok && full_q && !deliver;
         if (!gate_ok) begin
            // withdraw any word the reader has not yet taken
            valid_q <= 1'b0;
            word_q <= '0;
         end else if (deliver) begin
            valid_q <= 1'b1;
            word_q <= sr_q;
         end else if (RD_ACK) begin
            // a taken word is not left on the pins
            valid_q <= 1'b0;
            word_q <= '0;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ACTIVE <= 1'b0;
      end else begin
         ACTIVE <= (state_d == RHG_RUN);
      end
   end

   assign RND_WORD = word_q;
   assign RND_VALID = valid_q;
   assign FAIL_TOTAL = f_total_q;
   assign FAIL_ONLINE = f_online_q;
   assign FAIL_HEALTH = f_health_q;
   assign FAIL_MALF = f_malf_q;
   assign FAIL_SW = f_sw_q;
endmodule // rhg_top

// *** src/rhg_pkg.sv ***
// constants and types shared by the random number health gate
// How it works
// - total-failure test from start; fail blocks output
// - drop words holding bits after total failure
// - online statistical test at start-up and running
// - no output before start-up pass or after defect
// - online test runs continuously on every bit
// - each delivered random number is 16 bits
// - entropy per bit above 0.997; neither the logic nor the bench checks it
// - alternative mode: health test failure disables generator
// - alternative mode: malfunction detected, no numbers produced
// - software test failure shuts generator, flags error
// - post-processing fault or attack switches generator off; the code acts on PP_FAULT in alternative mode only
package rhg_pkg;

   // ----------------------------------------------------------------
   // word and test geometry
   // ----------------------------------------------------------------
   localparam int RHG_WORD_W = 16;
   localparam int RHG_WIN_BITS = 1024;
   localparam int RHG_RC_LIMIT = 32;
   localparam int RHG_ON_LO = 410;
   localparam int RHG_ON_HI = 614;
   localparam int RHG_HT_LO = 256;
   localparam int RHG_HT_HI = 768;
   localparam int RHG_STARTUP_WINS = 1;
   // verification target only, thousandths of a bit
   localparam int RHG_ENTROPY_MIN_MILLI = 997;

   // ----------------------------------------------------------------
   // generator states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RHG_OFF,
      RHG_STARTUP,
      RHG_RUN,
      RHG_FAILED
   } rhg_state_t;

endpackage

// *** src/rhg_health.sv ***
// raw bit health tests: repetition count and windowed proportion
`timescale 1ns/100ps
module rhg_health #(
   parameter int WIN_BITS = rhg_pkg::RHG_WIN_BITS,
   parameter int RC_LIMIT = rhg_pkg::RHG_RC_LIMIT
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic clear,
   // raw bit stream
   input wire logic bit_valid,
   input wire logic bit_in,
   // results, registered; total_fail stays high for each further equal bit of the run
   output logic total_fail,
   output logic online_fail,
   output logic health_fail,
   output logic win_done
);
   import rhg_pkg::*;

   localparam int CW = $clog2(WIN_BITS + 1);
   localparam int RW = $clog2(RC_LIMIT + 1);

   logic last_q;
   logic [RW-1:0] run_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] ones_q;
   logic total_q, online_q, health_q, done_q;

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   wire same_bit = (bit_in == last_q) && (run_q != '0);
   wire [RW-1:0] run_d = same_bit ? RW'(run_q + 1'b1) : RW'(1);
   wire [CW-1:0] ones_d = CW'(ones_q + {{(CW-1){1'b0}}, bit_in});
   wire last_of_win = (cnt_q == CW'(WIN_BITS - 1));
   // stuck source: long run of one value counts as total failure
   wire rc_hit = (run_d >= RW'(RC_LIMIT));
   // proportion of ones over one window, tested on the last bit of each window
   wire on_bad = (ones_d < CW'(RHG_ON_LO)) || (ones_d > CW'(RHG_ON_HI));
   // only gross bias counts as severe degradation
   wire ht_bad = (ones_d < CW'(RHG_HT_LO)) || (ones_d > CW'(RHG_HT_HI));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_q <= 1'b0;
         run_q <= '0;
         cnt_q <= '0;
         ones_q <= '0;
      end else if (clear) begin
         run_q <= '0;
         cnt_q <= '0;
         ones_q <= '0;
      end else if (bit_valid) begin
         last_q <= bit_in;
         run_q <= rc_hit ? RW'(RC_LIMIT) : run_d;
         cnt_q <= last_of_win ? '0 : CW'(cnt_q + 1'b1);
         ones_q <= last_of_win ? '0 : ones_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         total_q <= 1'b0;
         online_q <= 1'b0;
         health_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         total_q <= !clear && bit_valid && rc_hit;
         online_q <= !clear && bit_valid && last_of_win && on_bad;
         health_q <= !clear && bit_valid && last_of_win && ht_bad;
         done_q <= !clear && bit_valid && last_of_win;
      end
   end

   assign total_fail = total_q;
   assign online_fail = online_q;
   assign health_fail = health_q;
   assign win_done = done_q;
endmodule // rhg_health

// *** test/rhg_top_chk.sv ***
// port assertions for the random number health gate
`timescale 1ns/100ps
module rhg_top_chk #(
   parameter int WORD_W = 16,
   parameter int RC_LIMIT = 32
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // inputs
   input wire logic START,
   input wire logic ALT_MODE,
   input wire logic RAW_VALID,
   input wire logic RAW_BIT,
   input wire logic PP_FAULT,
   input wire logic SW_FAIL,
   input wire logic RD_ACK,
   // outputs
   input wire logic [WORD_W-1:0] RND_WORD,
   input wire logic RND_VALID,
   input wire logic ACTIVE,
   input wire logic FAIL_TOTAL,
   input wire logic FAIL_ONLINE,
   input wire logic FAIL_HEALTH,
   input wire logic FAIL_MALF,
   input wire logic FAIL_SW
);
   wire logic [4:0] fails = {FAIL_TOTAL, FAIL_ONLINE, FAIL_HEALTH, FAIL_MALF, FAIL_SW};
   wire logic fail_any = |fails;
   logic last_q;
   int run_q;
   // equal-bit run, restarted by a stop
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         last_q <= 1'b0;
         run_q <= 0;
      end else if (!START) begin
         run_q <= 0;
      end else if (RAW_VALID) begin
         last_q <= RAW_BIT;
         run_q <= (RAW_BIT == last_q) ? run_q + 1 : 1;
      end
   end
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   a_valid_active: assert property (RND_VALID |-> ACTIVE && !fail_any)
      else $error("word valid while inactive");
   a_word_idle: assert property (!RND_VALID |-> RND_WORD == '0)
      else $error("word shown while not valid");
   a_fail_blocks: assert property (fail_any |-> !ACTIVE)
      else $error("active after failure");
   a_fail_sticky: assert property (START && $past(START)
      |-> (fails & $past(fails)) == $past(fails))
      else $error("failure flag lost");
   // flag rises two edges after the run's last bit, one edge of slack
   a_total_run: assert property (
      START && RAW_VALID && RAW_BIT == last_q && run_q == RC_LIMIT - 1 |-> ##[1:3] FAIL_TOTAL)
      else $error("equal run not flagged");
   a_sw_fail: assert property (ACTIVE && SW_FAIL |-> ##[1:2] FAIL_SW)
      else $error("software failure not flagged");
   a_malf_alt: assert property (ACTIVE && ALT_MODE && PP_FAULT |-> ##[1:2] FAIL_MALF)
      else $error("fault not flagged");
   a_malf_mode: assert property ($rose(FAIL_MALF) |-> $past(ALT_MODE))
      else $error("fault flagged outside alt mode");
   a_health_mode: assert property ($rose(FAIL_HEALTH) |-> $past(ALT_MODE))
      else $error("health flagged outside alt mode");
   a_valid_stands: assert property (RND_VALID && !RD_ACK && START |=> RND_VALID || fail_any)
      else $error("word dropped unread");
   a_stop_clears: assert property (!START [*3] |-> !ACTIVE && !RND_VALID && !fail_any)
      else $error("stop left state behind");
endmodule // rhg_top_chk
bind rhg_top rhg_top_chk #(.WORD_W(WORD_W), .RC_LIMIT(RC_LIMIT)) u_chk (
   .CLK(CLK), .RST_N(RST_N), .START(START), .ALT_MODE(ALT_MODE), .RAW_VALID(RAW_VALID),
   .RAW_BIT(RAW_BIT), .PP_FAULT(PP_FAULT), .SW_FAIL(SW_FAIL), .RD_ACK(RD_ACK),
   .RND_WORD(RND_WORD), .RND_VALID(RND_VALID), .ACTIVE(ACTIVE), .FAIL_TOTAL(FAIL_TOTAL),
   .FAIL_ONLINE(FAIL_ONLINE), .FAIL_HEALTH(FAIL_HEALTH), .FAIL_MALF(FAIL_MALF),
   .FAIL_SW(FAIL_SW)
);

// *** test/rhg_reader.sv ***
// reader model: takes each word after a set wait
`timescale 1ns/100ps
module rhg_reader (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // word interface
   input wire logic [15:0] word,
   input wire logic valid,
   output logic ack,
   // wait and results
   input wire logic [3:0] dly,
   output logic [15:0] got,
   output logic [7:0] cnt
);
   logic [3:0] wait_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         wait_q <= 4'h0;
         got <= 16'h0000;
         cnt <= 8'h00;
      end else if (ack) begin
         ack <= 1'b0;
         wait_q <= 4'h0;
         // a word withdrawn by a failure is not counted
         if (valid) begin
            got <= word;
            cnt <= cnt + 8'h01;
         end
      end else if (valid && wait_q == dly) begin
         ack <= 1'b1;
      end else begin
         wait_q <= valid ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule // rhg_reader

// *** test/rhg_top_tb.sv ***
// self-checking bench for the random number health gate
`timescale 1ns/100ps
`define CHK(n, e, g) \
   begin \
      tests_run++; \
      if ((g) !== (e)) begin \
         $display("ERROR %s expected %0h seen %0h", n, e, g); \
         err_count++; \
      end \
   end
module rhg_top_tb;
   import rhg_pkg::*;
   // short window, still above the upper ones bound
   localparam int WIN = 700;
   logic CLK, RST_N, START, ALT_MODE, RAW_VALID, RAW_BIT, PP_FAULT, SW_FAIL;
   logic RD_ACK, RND_VALID, ACTIVE;
   logic [4:0] fails;
   logic [15:0] RND_WORD, got, exp_w;
   logic [7:0] cnt;
   logic [3:0] dly;
   int idx, err_count, tests_run;
   rhg_top #(.WIN_BITS(WIN)) dut (
      .CLK(CLK), .RST_N(RST_N), .START(START), .ALT_MODE(ALT_MODE), .RAW_VALID(RAW_VALID),
      .RAW_BIT(RAW_BIT), .PP_FAULT(PP_FAULT), .SW_FAIL(SW_FAIL), .RND_WORD(RND_WORD),
      .RND_VALID(RND_VALID), .RD_ACK(RD_ACK), .ACTIVE(ACTIVE), .FAIL_TOTAL(fails[4]),
      .FAIL_ONLINE(fails[3]), .FAIL_HEALTH(fails[2]), .FAIL_MALF(fails[1]), .FAIL_SW(fails[0])
   );
   rhg_reader u_rd (
      .clk(CLK), .rst_n(RST_N), .word(RND_WORD), .valid(RND_VALID), .ack(RD_ACK), .dly(dly),
      .got(got), .cnt(cnt)
   );
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   // k ones in every 7 bits: any window of 7*m bits holds k*m ones, runs stay short unless k is 0 or 7
   task automatic feed(input int n, input int k);
      logic b;
      repeat (n) begin
         @(posedge CLK);
         b = (idx % 7) < k;
         RAW_VALID <= 1'b1;
         RAW_BIT <= b;
         exp_w = {exp_w[14:0], b};
         idx++;
      end
      @(posedge CLK);
      RAW_VALID <= 1'b0;
      #1;
   endtask
   task automatic restart(input logic alt);
      @(posedge CLK);
      START <= 1'b0;
      ALT_MODE <= alt;
      tick(4);
      `CHK("flags", 5'h00, fails)
      @(posedge CLK);
      START <= 1'b1;
   endtask
   task automatic pulse(input int sw);
      @(posedge CLK);
      if (sw) SW_FAIL <= 1'b1;
      else PP_FAULT <= 1'b1;
      @(posedge CLK);
      SW_FAIL <= 1'b0;
      PP_FAULT <= 1'b0;
      tick(3);
   endtask
   task automatic t_startup(input logic alt);
      restart(alt);
      feed(WIN - 100, 5);
      `CHK("early", 1'b0, ACTIVE)
      feed(100, 5);
      tick(3);
      `CHK("active", 1'b1, ACTIVE)
   endtask
   task automatic t_words();
      logic [7:0] c0;
      for (int w = 0; w < 4; w++) begin
         c0 = cnt;
         dly <= (w == 3) ? 4'h9 : 4'h0;
         feed(16, 5);
         for (int i = 0; i < 40 && cnt == c0; i++) tick(1);
         `CHK("word", exp_w, got)
         `CHK("count", c0 + 8'h01, cnt)
      end
   endtask
   task automatic t_total();
      logic [7:0] c0;
      c0 = cnt;
      dly <= 4'h0;
      feed(32, 7);
      tick(4);
      `CHK("total", 5'h10, fails)
      `CHK("act_tot", 1'b0, ACTIVE)
      feed(32, 5);
      tick(6);
      `CHK("no_word", c0 + 8'h01, cnt)
   endtask
   task automatic t_online();
      for (int a = 0; a < 2; a++) begin
         restart(a[0]);
         feed(WIN, 2);
         tick(4);
         `CHK("online", {1'b0, 1'b1, a[0], 2'b00}, fails)
         `CHK("act_onl", 1'b0, ACTIVE)
      end
   endtask
   task automatic t_faults();
      t_startup(1'b0);
      pulse(0);
      `CHK("pp_off", 5'h00, fails)
      pulse(1);
      `CHK("sw", 5'h01, fails)
      `CHK("act_sw", 1'b0, ACTIVE)
      t_startup(1'b1);
      pulse(0);
      `CHK("malf", 5'h02, fails)
      `CHK("act_malf", 1'b0, ACTIVE)
   endtask
   task automatic results();
      if (err_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   initial begin
      {RST_N, START, ALT_MODE, RAW_VALID, RAW_BIT, PP_FAULT, SW_FAIL} = 7'h00;
      dly = 4'h0;
      exp_w = 16'h0000;
      repeat (2) @(posedge CLK);
      RST_N <= 1'b1;
      t_startup(1'b0);
      t_words();
      t_total();
      t_online();
      t_faults();
      results();
   end
   // the tests need about 3750 cycles
   initial begin
      repeat (20000) @(posedge CLK);
      err_count++;
      results();
   end
endmodule // rhg_top_tb
